// file: src/dsp_sequencer.sv
// How it works
// - water selection with paddle opens water valve
// - ice selection runs auger, cube needs solenoid
// - door open: one 30 ms relay pulse
// - door switch open means ice door open
// - paddle release: 10 ms unlock relay pulse
// - door still open: repeat unlock pulse
// - lights on with paddle or light pad
// - light setting keeps pocket lights always on
// - open freezer door blocks ice outputs only
// - no paddle, no dispensing or auto light
// - when dispensing, auger and solenoid need flapper confirmed open
// - both freezer keys held enter service mode
// - fresh-food up steps, on/off runs test
// - test 24 shows freezer door open/closed
// - test 10 auger, 10a stops on switch
// - test 11 solenoid, test 8 water valve
module dsp_sequencer #(
  parameter int OPEN_CYC = dsp_pkg::OPEN_PULSE_CYC,
  parameter int UNLOCK_CYC = dsp_pkg::UNLOCK_PULSE_CYC,
  parameter int SETTLE_CYC = dsp_pkg::SETTLE_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // dispenser switches
  input wire logic paddleSw,
  input wire logic iceDoorSwClosed,
  input wire logic frzDoorSwClosed,
  input wire logic flapperSwOpen,
  input wire logic augerSwClosed,
  // front panel board
  input wire logic [1:0] selCode,
  input wire logic lightPad,
  input wire logic lightAlways,
  input wire logic keyFrzDown,
  input wire logic keyFrzUp,
  input wire logic keyFfUp,
  input wire logic keyOnOff,
  // actuators
  output logic waterValve,
  output logic augerMotor,
  output logic cubeSolenoid,
  output logic flapperSolenoid,
  output logic doorRelay,
  output logic pocketLight,
  // service display
  output logic serviceActive,
  output logic [2:0] testIndex,
  output logic [7:0] displayCode
);
  localparam int NPIN = 13;

  logic [NPIN-1:0] pinMeta_r; // first synchroniser stage
  logic [NPIN-1:0] pinSync_r; // second synchroniser stage
  logic [NPIN-1:0] pinPrev_r; // last value, for edge detection
  logic paddleS, doorClosedS, frzClosedS, flapOpenS, augerSwS;
  logic [1:0] selS;
  logic padS, alwaysS, frzDnS, frzUpS, ffUpS, onOffS;
  logic comboRise, ffUpRise, onOffRise, padRise;
  logic iceDoorOpen;
  dsp_pkg::dsp_state_t state_r, state_nxt;
  logic [1:0] sel_r; // selection taken at paddle press
  logic [dsp_pkg::CNT_W-1:0] settle_r; // settle countdown
  logic testRun_r; // selected service test is running
  logic padLight_r; // light pad toggle
  logic svcRun;
  logic water_nxt, auger_nxt, cube_nxt, flap_nxt, light_nxt;
  logic [7:0] disp_nxt;
  logic [dsp_pkg::CNT_W-1:0] relayRun_r; // helper: relay high length
  dsp_pulse_if pulse ();

  ////////////////////////////////////////////////////////////////////////
  // every pin passes two flip-flops before use
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinPrev_r <= '0;
    end else if (ce) begin
      pinMeta_r <= {paddleSw, iceDoorSwClosed, frzDoorSwClosed, flapperSwOpen, augerSwClosed,
                    selCode, lightPad, lightAlways, keyFrzDown, keyFrzUp, keyFfUp, keyOnOff};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  assign {paddleS, doorClosedS, frzClosedS, flapOpenS, augerSwS, selS,
          padS, alwaysS, frzDnS, frzUpS, ffUpS, onOffS} = pinSync_r;
  // open contacts on the ice door switch mean the door stands open
  assign iceDoorOpen = !doorClosedS;
  // press edges of keys and of the two-key combination
  assign comboRise = frzDnS && frzUpS && !(pinPrev_r[3] && pinPrev_r[2]);
  assign ffUpRise = ffUpS && !pinPrev_r[1];
  assign onOffRise = onOffS && !pinPrev_r[0];
  assign padRise = padS && !pinPrev_r[5];

  ////////////////////////////////////////////////////////////////////////
  // relay pulse timer
  dsp_pulse_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .pulse(pulse.timer)
  );

  // start requests and lengths for the timer
  always_comb begin
    pulse.start = 1'b0;
    pulse.len = UNLOCK_CYC[dsp_pkg::CNT_W-1:0];
    unique case (state_r)
      dsp_pkg::ST_IDLE: begin
        // ice press opens the ice door
        pulse.start = !comboRise && paddleS && selS[1];
        pulse.len = OPEN_CYC[dsp_pkg::CNT_W-1:0];
      end
      dsp_pkg::ST_DISPENSE: begin
        // release: latch unlock, after outputs have dropped
        pulse.start = !paddleS && (sel_r[1] || iceDoorOpen);
      end
      dsp_pkg::ST_SETTLE: begin
        // door still open after the wait: try again
        pulse.start = settle_r == '0 && iceDoorOpen;
      end
      dsp_pkg::ST_OPENING, dsp_pkg::ST_UNLOCK, dsp_pkg::ST_SERVICE: begin
        pulse.start = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dsp_pkg::ST_IDLE: begin
        if (comboRise) begin
          state_nxt = dsp_pkg::ST_SERVICE;
        end else if (paddleS && selS == dsp_pkg::SEL_WATER) begin
          state_nxt = dsp_pkg::ST_DISPENSE;
        end else if (pulse.start) begin
          state_nxt = dsp_pkg::ST_OPENING;
        end
      end
      dsp_pkg::ST_OPENING: begin
        if (pulse.done) begin
          state_nxt = dsp_pkg::ST_DISPENSE;
        end
      end
      dsp_pkg::ST_DISPENSE: begin
        if (pulse.start) begin
          state_nxt = dsp_pkg::ST_UNLOCK;
        end else if (!paddleS) begin
          state_nxt = dsp_pkg::ST_IDLE;
        end
      end
      dsp_pkg::ST_UNLOCK: begin
        if (pulse.done) begin
          state_nxt = dsp_pkg::ST_SETTLE;
        end
      end
      dsp_pkg::ST_SETTLE: begin
        if (pulse.start) begin
          state_nxt = dsp_pkg::ST_UNLOCK;
        end else if (settle_r == '0) begin
          state_nxt = dsp_pkg::ST_IDLE;
        end
      end
      dsp_pkg::ST_SERVICE: begin
        if (comboRise) begin
          state_nxt = dsp_pkg::ST_IDLE;
        end
      end
      default: state_nxt = dsp_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= dsp_pkg::ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // selection held for the whole dispense
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_r <= dsp_pkg::SEL_NONE;
    end else if (ce && state_r == dsp_pkg::ST_IDLE) begin
      sel_r <= selS;
    end
  end

  // wait for the spring to close the door after each unlock pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      settle_r <= '0;
    end else if (ce) begin
      if (state_r == dsp_pkg::ST_UNLOCK) begin
        settle_r <= SETTLE_CYC[dsp_pkg::CNT_W-1:0];
      end else if (settle_r != '0) begin
        settle_r <= settle_r - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // service menu: step with fresh-food up, run with on/off
  always_ff @(posedge mclk) begin
    if (reset) begin
      testIndex <= dsp_pkg::T_WATER;
      testRun_r <= 1'b0;
    end else if (ce) begin
      if (state_r != dsp_pkg::ST_SERVICE) begin
        testIndex <= dsp_pkg::T_WATER;
        testRun_r <= 1'b0;
      end else if (ffUpRise) begin
        testIndex <= testIndex + 3'h1;
        testRun_r <= 1'b0;
      end else if (onOffRise) begin
        testRun_r <= !testRun_r;
      end
    end
  end

  assign svcRun = state_r == dsp_pkg::ST_SERVICE && testRun_r;

  ////////////////////////////////////////////////////////////////////////
  // actuator decisions
  always_comb begin
    // normal dispensing needs the paddle held
    logic disp;
    disp = state_r == dsp_pkg::ST_DISPENSE && paddleS;
    water_nxt = (disp && sel_r == dsp_pkg::SEL_WATER) ||
                (svcRun && testIndex == dsp_pkg::T_WATER);
    // freezer door must be closed for every ice actuator
    flap_nxt = frzClosedS && ((disp && sel_r[1]) ||
               (svcRun && testIndex == dsp_pkg::T_FLAP_SOL));
    // when dispensing, auger needs flapper driven and confirmed open
    auger_nxt = frzClosedS && ((disp && sel_r[1] && flapperSolenoid && flapOpenS) ||
                (svcRun && testIndex == dsp_pkg::T_AUGER) ||
                (svcRun && testIndex == dsp_pkg::T_AUGER_SW && augerSwS));
    cube_nxt = frzClosedS && ((disp && sel_r == dsp_pkg::SEL_CUBE && flapperSolenoid && flapOpenS) ||
               (svcRun && testIndex == dsp_pkg::T_CUBE));
    // pocket light: setting, pad toggle, or paddle
    light_nxt = alwaysS || padLight_r ||
                (paddleS && state_r != dsp_pkg::ST_SERVICE);
  end

  // light pad toggles the pocket light
  always_ff @(posedge mclk) begin
    if (reset) begin
      padLight_r <= 1'b0;
    end else if (ce && padRise) begin
      padLight_r <= !padLight_r;
    end
  end

  // actuator registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      waterValve <= 1'b0;
      augerMotor <= 1'b0;
      cubeSolenoid <= 1'b0;
      flapperSolenoid <= 1'b0;
      pocketLight <= 1'b0;
      doorRelay <= 1'b0;
    end else if (ce) begin
      waterValve <= water_nxt;
      augerMotor <= auger_nxt;
      cubeSolenoid <= cube_nxt;
      flapperSolenoid <= flap_nxt;
      pocketLight <= light_nxt;
      doorRelay <= pulse.busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // service display
  always_comb begin
    disp_nxt = dsp_pkg::DISP_BLANK;
    if (state_r == dsp_pkg::ST_SERVICE) begin
      unique case (testIndex)
        dsp_pkg::T_FRZ_DOOR: disp_nxt = frzClosedS ? dsp_pkg::CLOSED_DISPLAY_CODE
                                                    : dsp_pkg::OPEN_DISPLAY_CODE;
        dsp_pkg::T_PADDLE: disp_nxt = paddleS ? dsp_pkg::ON_DISPLAY_CODE : dsp_pkg::OFF_DISPLAY_CODE;
        dsp_pkg::T_FLAP_SW, dsp_pkg::T_FLAP_SOL: disp_nxt = flapOpenS ? dsp_pkg::OPEN_DISPLAY_CODE
                                                                       : dsp_pkg::CLOSED_DISPLAY_CODE;
        default: disp_nxt = dsp_pkg::DISP_BLANK;
      endcase
    end
  end

  // display and mode registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      displayCode <= dsp_pkg::DISP_BLANK;
      serviceActive <= 1'b0;
    end else if (ce) begin
      displayCode <= disp_nxt;
      serviceActive <= state_nxt == dsp_pkg::ST_SERVICE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helper: length of the current relay pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      relayRun_r <= '0;
    end else if (ce) begin
      relayRun_r <= pulse.busy ? relayRun_r + 1'b1 : '0;
    end
  end

  property p_waterNeedsPaddle;
    @(posedge mclk) disable iff (reset) waterValve && !$past(serviceActive) |-> $past(paddleS);
  endproperty
  a_waterNeedsPaddle: assert property (p_waterNeedsPaddle) else $error("water without paddle");

  property p_iceInterlock;
    @(posedge mclk) disable iff (reset)
      (augerMotor || cubeSolenoid || flapperSolenoid) |-> $past(frzClosedS);
  endproperty
  a_iceInterlock: assert property (p_iceInterlock) else $error("ice output with freezer door open");

  property p_flapperFirst;
    @(posedge mclk) disable iff (reset)
      augerMotor && !$past(serviceActive) |-> $past(flapperSolenoid) && $past(flapOpenS);
  endproperty
  a_flapperFirst: assert property (p_flapperFirst) else $error("auger without open flapper");

  property p_releaseDrops;
    @(posedge mclk) disable iff (reset)
      ce && state_r == dsp_pkg::ST_DISPENSE && !paddleS |=> !waterValve && !augerMotor && !cubeSolenoid;
  endproperty
  a_releaseDrops: assert property (p_releaseDrops) else $error("outputs held after release");

  property p_relayLength;
    @(posedge mclk) disable iff (reset)
      ce && $fell(pulse.busy) |-> relayRun_r == OPEN_CYC[dsp_pkg::CNT_W-1:0] ||
                                  relayRun_r == UNLOCK_CYC[dsp_pkg::CNT_W-1:0];
  endproperty
  a_relayLength: assert property (p_relayLength) else $error("relay pulse length wrong");

  property p_retryUnlock;
    @(posedge mclk) disable iff (reset)
      ce && state_r == dsp_pkg::ST_SETTLE && settle_r == '0 && iceDoorOpen |=> state_r == dsp_pkg::ST_UNLOCK;
  endproperty
  a_retryUnlock: assert property (p_retryUnlock) else $error("no retry with door open");

  property p_lightPaddle;
    @(posedge mclk) disable iff (reset)
      ce && (alwaysS || (paddleS && state_r != dsp_pkg::ST_SERVICE)) |=> pocketLight;
  endproperty
  a_lightPaddle: assert property (p_lightPaddle) else $error("pocket light off");

  property p_serviceEnter;
    @(posedge mclk) disable iff (reset)
      ce && state_r == dsp_pkg::ST_IDLE && comboRise |=> serviceActive;
  endproperty
  a_serviceEnter: assert property (p_serviceEnter) else $error("service mode not entered");

  property p_menuStep;
    @(posedge mclk) disable iff (reset)
      ce && state_r == dsp_pkg::ST_SERVICE && ffUpRise |=> testIndex == $past(testIndex) + 3'h1;
  endproperty
  a_menuStep: assert property (p_menuStep) else $error("menu did not step");

  property p_doorCode;
    @(posedge mclk) disable iff (reset)
      ce && state_r == dsp_pkg::ST_SERVICE && testIndex == dsp_pkg::T_FRZ_DOOR && !frzClosedS
      |=> displayCode == dsp_pkg::OPEN_DISPLAY_CODE;
  endproperty
  a_doorCode: assert property (p_doorCode) else $error("door code wrong");

  // retry condition for the cover below
  logic a_retryCond;
  assign a_retryCond = state_r == dsp_pkg::ST_SETTLE && pulse.start;

  c_waterDispense: cover property (@(posedge mclk) disable iff (reset) waterValve);
  c_iceDispense: cover property (@(posedge mclk) disable iff (reset) augerMotor && cubeSolenoid);
  c_retry: cover property (@(posedge mclk) disable iff (reset) a_retryCond);
  c_serviceRun: cover property (@(posedge mclk) disable iff (reset) svcRun && augerMotor);
endmodule // dsp_sequencer

// file: src/dsp_pkg.sv
package dsp_pkg;
  // clock rate, kHz, so that products stay well below 2**31
  localparam int CLK_KHZ = 200_000;
  // relay pulse lengths and door settle wait, in milliseconds
  localparam int OPEN_PULSE_MS = 30;
  localparam int UNLOCK_PULSE_MS = 10;
  localparam int SETTLE_MS = 20;
  // the same times as clock cycles
  localparam int OPEN_PULSE_CYC = OPEN_PULSE_MS * CLK_KHZ;
  localparam int UNLOCK_PULSE_CYC = UNLOCK_PULSE_MS * CLK_KHZ;
  localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
  // width of the cycle counters
  localparam int CNT_W = 24;
  // selection codes from the front panel board
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_WATER = 2'h1;
  localparam logic [1:0] SEL_CUBE = 2'h2;
  localparam logic [1:0] SEL_CRUSH = 2'h3;
  // service menu entries, in stepping order
  localparam int TEST_NUM = 8;
  localparam logic [2:0] T_WATER = 3'h0;
  localparam logic [2:0] T_AUGER = 3'h1;
  localparam logic [2:0] T_AUGER_SW = 3'h2;
  localparam logic [2:0] T_CUBE = 3'h3;
  localparam logic [2:0] T_FRZ_DOOR = 3'h4;
  localparam logic [2:0] T_PADDLE = 3'h5;
  localparam logic [2:0] T_FLAP_SW = 3'h6;
  localparam logic [2:0] T_FLAP_SOL = 3'h7;
  // display codes
  localparam logic [7:0] DISP_BLANK = 8'h00;
  localparam logic [7:0] OPEN_DISPLAY_CODE = 8'h01;
  localparam logic [7:0] CLOSED_DISPLAY_CODE = 8'h02;
  localparam logic [7:0] ON_DISPLAY_CODE = 8'h03;
  localparam logic [7:0] OFF_DISPLAY_CODE = 8'h04;
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPENING = 6'h02,
    ST_DISPENSE = 6'h04,
    ST_UNLOCK = 6'h08,
    ST_SETTLE = 6'h10,
    ST_SERVICE = 6'h20
  } dsp_state_t;
endpackage

// file: src/dsp_pulse_if.sv
// request and status of the door relay pulse timer
interface dsp_pulse_if;
  logic start;
  logic [dsp_pkg::CNT_W-1:0] len;
  logic busy;
  logic done;
  modport ctrl (output start, output len, input busy, input done);
  modport timer (input start, input len, output busy, output done);
endinterface

// file: src/dsp_pulse_timer.sv
// relay pulse timer: busy stands exactly len cycles after start
module dsp_pulse_timer (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // request side
  dsp_pulse_if.timer pulse
);
  logic [dsp_pkg::CNT_W-1:0] cnt_r; // cycles left in the pulse

  //////////////////////////////////////////////////////////////////////
  // count the pulse down; a start while idle loads it
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= '0;
      pulse.busy <= 1'b0;
      pulse.done <= 1'b0;
    end else if (ce) begin
      pulse.done <= 1'b0;
      if (!pulse.busy && pulse.start) begin
        cnt_r <= pulse.len - 1'b1;
        pulse.busy <= 1'b1;
      end else if (pulse.busy) begin
        if (cnt_r == '0) begin
          pulse.busy <= 1'b0;
          pulse.done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // a busy pulse always ends in done
  property p_doneEndsBusy;
    @(posedge mclk) disable iff (reset) $fell(pulse.busy) |-> pulse.done;
  endproperty
  a_doneEndsBusy: assert property (p_doneEndsBusy) else $error("busy fell without done");
endmodule // dsp_pulse_timer

// file: tb/dsp_door_model.sv
// behavioural far side: ice door linkage, door switch and flapper
module dsp_door_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // actuator drives from the sequencer
  input wire logic doorRelay,
  input wire logic flapperSolenoid,
  // fault control: while high an unlock pulse fails to free the door
  input wire logic doorSticky,
  // switch feedback to the sequencer
  output logic iceDoorSwClosed,
  output logic flapperSwOpen
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  logic relay_r; // relay level one cycle ago
  logic [2:0] flap_r; // flapper travel delay line

  // door linkage: each relay pulse opens a closed door or, unless doorSticky, releases an open one
  always @(posedge mclk) begin
    if (reset) begin
      relay_r <= 1'b0;
      iceDoorSwClosed <= 1'b1;
    end else begin
      relay_r <= doorRelay;
      if (doorRelay && !relay_r) begin
        if (iceDoorSwClosed) begin
          // opening pulse: latch holds door, switch contacts open
          iceDoorSwClosed <= 1'b0;
        end else if (!doorSticky) begin
          // unlock pulse: spring closes door, contacts close
          iceDoorSwClosed <= 1'b1;
        end
      end
    end
  end

  // flapper switch confirms open a few cycles after the solenoid acts
  always @(posedge mclk) begin
    if (reset) begin
      flap_r <= 3'h0;
    end else begin
      flap_r <= {flap_r[1:0], flapperSolenoid};
    end
  end
  assign flapperSwOpen = flap_r[2];
endmodule // dsp_door_model

// file: tb/tb.sv
// self-checking bench for the dispenser sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  // shortened relay and settle times
  localparam int OPEN_N = 30;
  localparam int UNLOCK_N = 10;
  localparam int SETTLE_N = 20;
  logic mclk, reset, ce, paddleSw, frzDoorSwClosed, augerSwClosed;
  logic lightPad, lightAlways, keyFrzDown, keyFrzUp, keyFfUp, keyOnOff;
  logic [1:0] selCode;
  logic iceDoorSwClosed, flapperSwOpen, doorSticky;
  logic waterValve, augerMotor, cubeSolenoid, flapperSolenoid, doorRelay, pocketLight;
  logic serviceActive;
  logic [2:0] testIndex;
  logic [7:0] displayCode;
  logic actAtRise; // valve, auger, cube or flapper on when relay rose
  int errors = 0;
  int n_tests = 0;

  dsp_sequencer #(.OPEN_CYC(OPEN_N), .UNLOCK_CYC(UNLOCK_N), .SETTLE_CYC(SETTLE_N)) u_dut (
    .mclk(mclk), .reset(reset), .ce(ce), .paddleSw(paddleSw), .iceDoorSwClosed(iceDoorSwClosed),
    .frzDoorSwClosed(frzDoorSwClosed), .flapperSwOpen(flapperSwOpen), .augerSwClosed(augerSwClosed),
    .selCode(selCode), .lightPad(lightPad), .lightAlways(lightAlways), .keyFrzDown(keyFrzDown),
    .keyFrzUp(keyFrzUp), .keyFfUp(keyFfUp), .keyOnOff(keyOnOff), .waterValve(waterValve),
    .augerMotor(augerMotor), .cubeSolenoid(cubeSolenoid), .flapperSolenoid(flapperSolenoid),
    .doorRelay(doorRelay), .pocketLight(pocketLight), .serviceActive(serviceActive),
    .testIndex(testIndex), .displayCode(displayCode));

  dsp_door_model u_door (
    .mclk(mclk), .reset(reset), .doorRelay(doorRelay), .flapperSolenoid(flapperSolenoid),
    .doorSticky(doorSticky), .iceDoorSwClosed(iceDoorSwClosed), .flapperSwOpen(flapperSwOpen));

  ////////////////////////////////////////////////////////////////////////
  // clock generator, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // step n edges, land just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait for a relay pulse, note actuators at its rise, check its length
  task automatic relay_pulse(input int expLen);
    int n;
    n = 0;
    for (int i = 0; i < 200 && doorRelay !== 1'b1; i++) tick(1);
    actAtRise = waterValve | augerMotor | cubeSolenoid | flapperSolenoid;
    while (doorRelay === 1'b1 && n < 200) begin
      n++;
      tick(1);
    end
    check(32'(n), 32'(expLen));
  endtask

  // one key press: 0 fresh-food up, 1 on/off, else both freezer keys
  task automatic press(input int k);
    case (k)
      0: keyFfUp = 1'b1;
      1: keyOnOff = 1'b1;
      default: begin
        keyFrzDown = 1'b1;
        keyFrzUp = 1'b1;
      end
    endcase
    tick(4);
    {keyFfUp, keyOnOff, keyFrzDown, keyFrzUp} = 4'h0;
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // water: nothing without paddle, valve with it, no relay
  task automatic test_water();
    selCode = dsp_pkg::SEL_WATER;
    tick(8);
    check(32'({waterValve, pocketLight}), 32'h0000_0000);
    paddleSw = 1'b1;
    tick(8);
    check(32'({waterValve, augerMotor, doorRelay}), 32'h0000_0004);
    check(32'(pocketLight), 32'h0000_0001);
    paddleSw = 1'b0;
    tick(6);
    check(32'({waterValve, doorRelay, pocketLight}), 32'h0000_0000);
    selCode = dsp_pkg::SEL_NONE;
    tick(SETTLE_N);
    $display("test water done");
  endtask

  // cube: open pulse, gated auger, drop, two unlock pulses when door sticks
  task automatic test_cube();
    selCode = dsp_pkg::SEL_CUBE;
    paddleSw = 1'b1;
    relay_pulse(OPEN_N);
    check(32'(iceDoorSwClosed), 32'h0000_0000);
    check(32'({augerMotor, cubeSolenoid}), 32'h0000_0000);
    tick(15);
    check(32'({augerMotor, cubeSolenoid, flapperSolenoid, waterValve}), 32'h0000_000E);
    doorSticky = 1'b1;
    paddleSw = 1'b0;
    relay_pulse(UNLOCK_N);
    check(32'(actAtRise), 32'h0000_0000);
    doorSticky = 1'b0;
    relay_pulse(UNLOCK_N);
    check(32'(iceDoorSwClosed), 32'h0000_0001);
    tick(SETTLE_N + 5);
    check(32'(doorRelay), 32'h0000_0000);
    selCode = dsp_pkg::SEL_NONE;
    tick(5);
    $display("test cube done");
  endtask

  // crush with freezer door open: ice outputs blocked until it closes
  task automatic test_crush_blocked();
    frzDoorSwClosed = 1'b0;
    selCode = dsp_pkg::SEL_CRUSH;
    paddleSw = 1'b1;
    relay_pulse(OPEN_N);
    tick(15);
    check(32'({augerMotor, cubeSolenoid, flapperSolenoid}), 32'h0000_0000);
    frzDoorSwClosed = 1'b1;
    tick(15);
    check(32'({augerMotor, cubeSolenoid, flapperSolenoid}), 32'h0000_0005);
    paddleSw = 1'b0;
    relay_pulse(UNLOCK_N);
    check(32'(actAtRise), 32'h0000_0000);
    selCode = dsp_pkg::SEL_NONE;
    tick(SETTLE_N + 5);
    $display("test crush done");
  endtask

  // lights: always-on setting, then pad toggling
  task automatic test_lights();
    lightAlways = 1'b1;
    tick(6);
    check(32'(pocketLight), 32'h0000_0001);
    lightAlways = 1'b0;
    tick(6);
    check(32'(pocketLight), 32'h0000_0000);
    lightPad = 1'b1;
    tick(4);
    lightPad = 1'b0;
    tick(4);
    check(32'(pocketLight), 32'h0000_0001);
    lightPad = 1'b1;
    tick(4);
    lightPad = 1'b0;
    tick(4);
    check(32'(pocketLight), 32'h0000_0000);
    $display("test lights done");
  endtask

  // service menu: enter, step, display, run tests, wrap, exit
  task automatic test_service();
    press(2);
    check(32'({serviceActive, testIndex}), 32'({1'b1, dsp_pkg::T_WATER}));
    repeat (4) press(0);
    check(32'(testIndex), 32'(dsp_pkg::T_FRZ_DOOR));
    check(32'(displayCode), 32'(dsp_pkg::CLOSED_DISPLAY_CODE));
    frzDoorSwClosed = 1'b0;
    tick(6);
    check(32'(displayCode), 32'(dsp_pkg::OPEN_DISPLAY_CODE));
    frzDoorSwClosed = 1'b1;
    press(0);
    check(32'(displayCode), 32'(dsp_pkg::OFF_DISPLAY_CODE));
    press(0);
    check(32'(displayCode), 32'(dsp_pkg::CLOSED_DISPLAY_CODE));
    press(0);
    press(1);
    tick(4);
    check(32'({flapperSolenoid, displayCode}), 32'({1'b1, dsp_pkg::OPEN_DISPLAY_CODE}));
    press(0);
    check(32'(testIndex), 32'(dsp_pkg::T_WATER));
    press(1);
    check(32'(waterValve), 32'h0000_0001);
    press(0);
    check(32'(waterValve), 32'h0000_0000);
    press(1);
    check(32'(augerMotor), 32'h0000_0001);
    press(0);
    press(1);
    augerSwClosed = 1'b0;
    tick(6);
    check(32'({testIndex, augerMotor}), 32'({dsp_pkg::T_AUGER_SW, 1'b0}));
    augerSwClosed = 1'b1;
    press(0);
    press(1);
    check(32'(cubeSolenoid), 32'h0000_0001);
    press(0);
    press(2);
    check(32'({serviceActive, cubeSolenoid}), 32'h0000_0000);
    $display("test service done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #100us;
    errors++;
    final_report();
  end

  // main sequence
  initial begin
    {reset, ce, paddleSw, frzDoorSwClosed, augerSwClosed} = 5'b11011;
    {lightPad, lightAlways, keyFrzDown, keyFrzUp, keyFfUp, keyOnOff} = 6'h00;
    selCode = dsp_pkg::SEL_NONE;
    doorSticky = 1'b0;
    tick(4);
    reset = 1'b0;
    tick(2);
    test_water();
    test_cube();
    test_crush_blocked();
    test_lights();
    test_service();
    final_report();
  end
endmodule // tb
